// *** ifp_ctrl.sv ***
// Function
// - Fixed reset values, except the cause and oscillator words, which follow reset kind
// - Oscillator reset from reset kind and configuration
// - Flags set by requests, read/write, reset 0
// - Enable bit 1 lets request through, reset 0
// - Priority 7 highest, 1 lowest, 0 disables
// - Unimplemented bits ignore writes, read zero
// - Flags word 0 timer flags at 8,7,3
// - Flags word 1 pin-change 3, I2C 1,0
// - Enables word 1 matches flags word 1
// - Priority word 7 holds four 3-bit fields
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ifp_ctrl
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [ifp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ifp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ifp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [ifp_pkg::DATA_W-1:0] src_set_0,
	input wire logic [ifp_pkg::DATA_W-1:0] src_set_1,
	input wire logic [ifp_pkg::XSRC-1:0] src_set_x,
	input wire logic [ifp_pkg::KIND_W-1:0] reset_kind,
	input wire logic [ifp_pkg::OSC_W-1:0] oscillator_config_word,
	output logic core_req_valid,
	output logic [ifp_pkg::PRIO_W-1:0] core_req_priority,
	output logic [ifp_pkg::IDX_W-1:0] core_req_source,
	output logic irq_out
);
	import ifp_pkg::*;

	// Software visible state
	logic [DATA_W-1:0] irq_flags_0_r;
	logic [DATA_W-1:0] irq_flags_1_r;
	logic [DATA_W-1:0] irq_enables_0_r;
	logic [DATA_W-1:0] irq_enables_1_r;
	logic [DATA_W-1:0] irq_priority_7_r;
	logic [DATA_W-1:0] irq_priority_17_r;
	logic [XSRC-1:0] flags_x_r; // Flags of prioritised sources
	logic [XSRC-1:0] enables_x_r; // Enables of prioritised sources
	logic [PRIO_W-1:0] group_prio_r; // Level for word 0/1 sources
	logic [DATA_W-1:0] status_r; // Sticky events
	logic [DATA_W-1:0] mask_r; // Event mask
	logic [DATA_W-1:0] reset_cause_control_r;
	logic [DATA_W-1:0] oscillator_control_r;
	// Outputs toward the core
	logic [DATA_W-1:0] rdata_r;
	logic req_valid_r;
	logic [PRIO_W-1:0] req_prio_r;
	logic [IDX_W-1:0] req_src_r;
	logic irq_r;

	// Next values
	logic [DATA_W-1:0] irq_flags_0_nxt;
	logic [DATA_W-1:0] irq_flags_1_nxt;
	logic [XSRC-1:0] flags_x_nxt;
	logic [DATA_W-1:0] status_nxt;
	logic [DATA_W-1:0] mask_nxt;
	logic [DATA_W-1:0] events;
	logic [DATA_W-1:0] cause_rst;
	logic [DATA_W-1:0] osc_rst;
	logic [OSC_W-1:0] osc_rst_src;
	logic rst_cold;

	// Write strobes, one per writable register
	wire wr_f0 = reg_wr && (reg_addr == OFF_FLAGS_0);
	wire wr_f1 = reg_wr && (reg_addr == OFF_FLAGS_1);
	wire wr_e0 = reg_wr && (reg_addr == OFF_ENABLES_0);
	wire wr_e1 = reg_wr && (reg_addr == OFF_ENABLES_1);
	wire wr_p7 = reg_wr && (reg_addr == OFF_PRIORITY_7);
	wire wr_p17 = reg_wr && (reg_addr == OFF_PRIORITY_17);
	wire wr_fx = reg_wr && (reg_addr == OFF_FLAGS_X);
	wire wr_ex = reg_wr && (reg_addr == OFF_ENABLES_X);
	wire wr_gp = reg_wr && (reg_addr == OFF_GROUP_PRIO);
	wire wr_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);
	wire wr_cause = reg_wr && (reg_addr == OFF_RESET_CAUSE);
	wire wr_osc = reg_wr && (reg_addr == OFF_OSC_CTL);
	// Reading status clears it
	wire rd_status = reg_rd && (reg_addr == OFF_IRQ_STATUS);

	// Read view of the pending request
	wire [DATA_W-1:0] req_view = {req_valid_r, 4'h0, req_prio_r,
		2'h0, req_src_r};

	// Read decode; unmapped addresses answer zero
	wire [DATA_W-1:0] rd_mux =
		(reg_addr == OFF_FLAGS_0) ? irq_flags_0_r :
		(reg_addr == OFF_FLAGS_1) ? irq_flags_1_r :
		(reg_addr == OFF_ENABLES_0) ? irq_enables_0_r :
		(reg_addr == OFF_ENABLES_1) ? irq_enables_1_r :
		(reg_addr == OFF_PRIORITY_7) ? irq_priority_7_r :
		(reg_addr == OFF_PRIORITY_17) ? irq_priority_17_r :
		(reg_addr == OFF_FLAGS_X) ? {8'h00, flags_x_r} :
		(reg_addr == OFF_ENABLES_X) ? {8'h00, enables_x_r} :
		(reg_addr == OFF_GROUP_PRIO) ? {13'h0000, group_prio_r} :
		(reg_addr == OFF_IRQ_STATUS) ? status_r :
		(reg_addr == OFF_IRQ_MASK) ? mask_r :
		(reg_addr == OFF_RESET_CAUSE) ? reset_cause_control_r :
		(reg_addr == OFF_OSC_CTL) ? oscillator_control_r :
		(reg_addr == OFF_REQ_VIEW) ? req_view : ZERO_RST;

	// hardware set wins over a same-cycle software clear
	assign irq_flags_0_nxt = ((wr_f0 ? reg_wdata : irq_flags_0_r)
		| src_set_0) & FLAGS_0_MASK;
	assign irq_flags_1_nxt = ((wr_f1 ? reg_wdata : irq_flags_1_r)
		| src_set_1) & FLAGS_1_MASK;
	assign flags_x_nxt = (wr_fx ? reg_wdata[XSRC-1:0] : flags_x_r)
		| src_set_x;

	// Request picker inputs
	logic [NSRC-1:0] req_vec;
	logic [NSRC*PRIO_W-1:0] prio_flat;
	wire [2*DATA_W-1:0] prio_words = {irq_priority_17_r,
		irq_priority_7_r};
	logic pick_valid;
	logic [PRIO_W-1:0] pick_prio;
	logic [IDX_W-1:0] pick_idx;

	genvar g;
	generate
		for (g = 0; g < DATA_W; g++)
		begin : g_base
			assign req_vec[g] = irq_flags_0_r[g] & irq_enables_0_r[g];
			assign req_vec[DATA_W+g] = irq_flags_1_r[g]
				& irq_enables_1_r[g];
			// Word 0/1 sources share one programmable level
			assign prio_flat[g*PRIO_W +: PRIO_W] = group_prio_r;
			assign prio_flat[(DATA_W+g)*PRIO_W +: PRIO_W] = group_prio_r;
		end
		for (g = 0; g < XSRC; g++)
		begin : g_ext
			// field k sits at 4k+2..4k of the priority words
			assign prio_flat[(2*DATA_W+g)*PRIO_W +: PRIO_W] =
				prio_words[g*FIELD_PITCH +: PRIO_W];
			assign req_vec[2*DATA_W+g] = flags_x_r[g] & enables_x_r[g];
		end
	endgenerate

	// zero level drops out inside the picker
	ifp_prio_pick u_pick
	(
		.req_vec(req_vec),
		.prio_flat(prio_flat),
		.best_valid(pick_valid),
		.best_prio(pick_prio),
		.best_idx(pick_idx)
	);

	// Events seen by the interrupt status word
	assign events = {14'h0000, (req_valid_r && !pick_valid),
		(pick_valid && !req_valid_r)};
	// Set wins over the read clear
	assign status_nxt = ((rd_status ? ZERO_RST : status_r) | events)
		& STATUS_MASK;
	assign mask_nxt = (wr_mask ? reg_wdata : mask_r) & STATUS_MASK;

	// cold resets reload from the configuration word
	assign rst_cold = (reset_kind == KIND_POWER_ON)
		|| (reset_kind == KIND_BROWN_OUT);
	// Warm resets keep the running clock, so no glitchy switch
	assign osc_rst_src = rst_cold ? oscillator_config_word :
		oscillator_control_r[OSC_CUR_LSB +: OSC_W];
	assign osc_rst = {1'b0, osc_rst_src, 1'b0, osc_rst_src, 8'h00};
	// Cause word records which kind of reset happened
	assign cause_rst = (CAUSE_ONE << reset_kind) & CAUSE_MASK;

	// Flag words
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			irq_flags_0_r <= ZERO_RST;
			irq_flags_1_r <= ZERO_RST;
			flags_x_r <= 8'h00;
		end
		else
		begin
			irq_flags_0_r <= irq_flags_0_nxt;
			irq_flags_1_r <= irq_flags_1_nxt;
			flags_x_r <= flags_x_nxt;
		end
	end

	// Enable words
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			irq_enables_0_r <= ZERO_RST;
			irq_enables_1_r <= ZERO_RST;
			enables_x_r <= 8'h00;
		end
		else
		begin
			// enable bits at the flag positions
			if (wr_e0)
				irq_enables_0_r <= reg_wdata & FLAGS_0_MASK;
			if (wr_e1)
				irq_enables_1_r <= reg_wdata & FLAGS_1_MASK;
			if (wr_ex)
				enables_x_r <= reg_wdata[XSRC-1:0];
		end
	end

	// Priority words
	always_ff @(posedge clk_sys)
	begin
		// priority fields reset to level 4
		if (sys_rst)
		begin
			irq_priority_7_r <= PRIO_RST;
			irq_priority_17_r <= PRIO_RST;
			group_prio_r <= GROUP_PRIO_RST;
		end
		else
		begin
			// gap bits between fields stay zero
			if (wr_p7)
				irq_priority_7_r <= reg_wdata & PRIO_MASK;
			if (wr_p17)
				irq_priority_17_r <= reg_wdata & PRIO_MASK;
			if (wr_gp)
				group_prio_r <= reg_wdata[PRIO_W-1:0];
		end
	end

	// Reset cause and oscillator words
	always_ff @(posedge clk_sys)
	begin
		// both depend on the kind of reset
		if (sys_rst)
		begin
			reset_cause_control_r <= cause_rst;
			oscillator_control_r <= osc_rst;
		end
		else
		begin
			// Software may clear cause bits
			if (wr_cause)
				reset_cause_control_r <= reg_wdata & CAUSE_MASK;
			// Only the requested-oscillator field is writable
			if (wr_osc)
				oscillator_control_r <= (oscillator_control_r
					& ~OSC_WR_MASK) | (reg_wdata & OSC_WR_MASK);
		end
	end

	// Interrupt status, mask and line
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			status_r <= ZERO_RST;
			mask_r <= ZERO_RST;
			irq_r <= 1'b0;
		end
		else
		begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			// Built from next values so the line tracks the bits
			irq_r <= |(status_nxt & mask_nxt);
		end
	end

	// Read data and request outputs
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rdata_r <= ZERO_RST;
			req_valid_r <= 1'b0;
			req_prio_r <= 3'h0;
			req_src_r <= 6'h00;
		end
		else
		begin
			// Data stands only in the cycle after the strobe
			rdata_r <= reg_rd ? rd_mux : ZERO_RST;
			req_valid_r <= pick_valid;
			req_prio_r <= pick_prio;
			req_src_r <= pick_idx;
		end
	end

	assign reg_rdata = rdata_r;
	assign core_req_valid = req_valid_r;
	assign core_req_priority = req_prio_r;
	assign core_req_source = req_src_r;
	assign irq_out = irq_r;

	// Checks on the block's own registers and outputs
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// timer C and A flags land at their bits, bit 15 zero
	timer_flag_a: assert property (src_set_0[TIMER_C_FLAG]
		&& src_set_0[TIMER_A_FLAG] |=> irq_flags_0_r[TIMER_C_FLAG]
		&& irq_flags_0_r[TIMER_A_FLAG] && !irq_flags_0_r[15])
		else $error("timer flag not captured");
	// pin change flag held, bit 2 zero
	pin_change_a: assert property (wr_f1 |=> !irq_flags_1_r[2]
		&& (irq_flags_1_r[PIN_CHANGE_FLAG]
		== ($past(reg_wdata[PIN_CHANGE_FLAG])
		|| $past(src_set_1[PIN_CHANGE_FLAG]))))
		else $error("flags word 1 layout wrong");
	// enable word 1 keeps only its three bits
	enable_one_a: assert property (wr_e1 |=> irq_enables_1_r
		== ($past(reg_wdata) & 16'h000b))
		else $error("enables word 1 wrong");
	flags_reset_a: assert property ($fell(sys_rst) |->
		irq_flags_0_r == 16'h0000 && irq_flags_1_r == 16'h0000
		&& flags_x_r == 8'h00)
		else $error("flags not cleared by reset");
	prio_reset_a: assert property ($fell(sys_rst) |->
		irq_priority_7_r == 16'h4444
		&& irq_priority_17_r == 16'h4444)
		else $error("priority reset value wrong");
	osc_reset_a: assert property ($fell(sys_rst)
		&& $past(reset_kind) == KIND_POWER_ON |->
		oscillator_control_r[OSC_CUR_LSB +: OSC_W]
		== $past(oscillator_config_word))
		else $error("oscillator reset value wrong");
	prio_gap_a: assert property (wr_p7 |=>
		(irq_priority_7_r & 16'h8888) == 16'h0000)
		else $error("priority gap bit set");
	// a forwarded request never has level zero
	level_zero_a: assert property (core_req_valid |->
		core_req_priority != 3'h0)
		else $error("level zero forwarded");
	// nothing forwarded without a gated request
	gate_req_a: assert property (!(|req_vec) |=>
		!core_req_valid)
		else $error("request without flag and enable");
	enable_gate_a: assert property (irq_enables_0_r == 16'h0000
		&& irq_enables_1_r == 16'h0000 && enables_x_r == 8'h00
		|=> !core_req_valid)
		else $error("request passed with enables off");
	// timer five field at level 7 wins as entry 32
	timer_e_a: assert property (req_vec[2*DATA_W]
		&& irq_priority_7_r[2:0] == 3'h7 && group_prio_r != 3'h7
		|=> core_req_priority == 3'h7 && core_req_source == 6'h20)
		else $error("timer five level wrong");
	// Interrupt line follows unmasked status
	irq_line_a: assert property (irq_out == |(status_r & mask_r))
		else $error("interrupt line mismatch");

	// Main scenarios
	req_fwd_c: cover property (!core_req_valid ##1 core_req_valid);
	status_rd_c: cover property (irq_out ##1 rd_status ##1 !irq_out);
	set_clear_c: cover property (wr_f0 && (|src_set_0));
	warm_rst_c: cover property ($fell(sys_rst) && !$past(rst_cold));
endmodule
`default_nettype wire

// *** ifp_pkg.sv ***
package ifp_pkg;
	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int PRIO_W = 3;
	localparam int NSRC = 40;
	localparam int IDX_W = 6;
	localparam int XSRC = 8;
	localparam int KIND_W = 3;
	// Register word indices on the plain port
	localparam logic [ADDR_W-1:0] OFF_FLAGS_0 = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_FLAGS_1 = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_ENABLES_0 = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_ENABLES_1 = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_PRIORITY_7 = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_PRIORITY_17 = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_FLAGS_X = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_ENABLES_X = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_GROUP_PRIO = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h9;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'ha;
	localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 4'hb;
	localparam logic [ADDR_W-1:0] OFF_OSC_CTL = 4'hc;
	localparam logic [ADDR_W-1:0] OFF_REQ_VIEW = 4'hd;
	// Implemented bit masks, all other bits read as zero; OSC_WR_MASK covers only the writable oscillator bits
	localparam logic [DATA_W-1:0] FLAGS_0_MASK = 16'h7fff;
	localparam logic [DATA_W-1:0] FLAGS_1_MASK = 16'h000b;
	localparam logic [DATA_W-1:0] PRIO_MASK = 16'h7777;
	localparam logic [DATA_W-1:0] STATUS_MASK = 16'h0003;
	localparam logic [DATA_W-1:0] CAUSE_MASK = 16'h00ff;
	localparam logic [DATA_W-1:0] OSC_WR_MASK = 16'h0700;
	// Flag positions inside the flag words
	localparam int TIMER_C_FLAG = 8;
	localparam int TIMER_B_FLAG = 7;
	localparam int TIMER_A_FLAG = 3;
	localparam int PIN_CHANGE_FLAG = 3;
	localparam int I2C_MASTER_EVENT_FLAG = 1;
	localparam int I2C_SLAVE_EVENT_FLAG = 0;
	// Priority field positions (low bit of each 3-bit field)
	localparam int TIMER_E_PRIORITY = 0;
	localparam int EXT_IRQ_B_PRIORITY = 4;
	localparam int UART_B_RX_PRIORITY = 8;
	localparam int UART_B_TX_PRIORITY = 12;
	localparam int FIELD_PITCH = 4;
	// Reset values
	localparam logic [DATA_W-1:0] ZERO_RST = 16'h0000;
	localparam logic [DATA_W-1:0] PRIO_RST = 16'h4444;
	localparam logic [PRIO_W-1:0] GROUP_PRIO_RST = 3'h4;
	localparam logic [DATA_W-1:0] CAUSE_ONE = 16'h0001;
	// Status event bits
	localparam int EV_REQ_RISE = 0;
	localparam int EV_REQ_FALL = 1;
	// Kinds of reset reported by the reset controller
	localparam logic [KIND_W-1:0] KIND_POWER_ON = 3'h0;
	localparam logic [KIND_W-1:0] KIND_BROWN_OUT = 3'h1;
	// Oscillator control field positions
	localparam int OSC_CUR_LSB = 12;
	localparam int OSC_NEW_LSB = 8;
	localparam int OSC_W = 3;
endpackage

// *** ifp_prio_pick.sv ***
`timescale 1ns/10ps
`default_nettype none
// Picks the pending source with the highest priority level.
// Ties go to the lowest entry index, so the order is stable.
module ifp_prio_pick
(
	input wire logic [ifp_pkg::NSRC-1:0] req_vec,
	input wire logic [ifp_pkg::NSRC*ifp_pkg::PRIO_W-1:0] prio_flat,
	output logic best_valid,
	output logic [ifp_pkg::PRIO_W-1:0] best_prio,
	output logic [ifp_pkg::IDX_W-1:0] best_idx
);
	import ifp_pkg::*;

	// Effective level per entry, zero when not requesting
	logic [PRIO_W-1:0] eff [NSRC];

	genvar g;
	generate
		for (g = 0; g < NSRC; g++)
		begin : g_eff
			// Level counts only for a live request
			assign eff[g] = req_vec[g] ?
				prio_flat[g*PRIO_W +: PRIO_W] : 3'h0;
		end
	endgenerate

	// Linear scan; strict compare keeps the lowest index on ties
	always_comb
	begin
		best_prio = 3'h0;
		best_idx = 6'h00;
		for (int i = 0; i < NSRC; i++)
		begin
			if (eff[i] > best_prio)
			begin
				best_prio = eff[i];
				best_idx = IDX_W'(i);
			end
		end
		best_valid = (best_prio != 3'h0);
	end
endmodule
`default_nettype wire

// *** ifp_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the processor core on the request side.
// It only watches: a real core fetches a vector later, so the
// block must hold its request level without any answer.
module ifp_core_model
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic [ifp_pkg::IDX_W-1:0] req_source,
	output logic [ifp_pkg::IDX_W-1:0] seen_source_r,
	output logic [15:0] seen_cnt_r
);
	import ifp_pkg::*;
	// Latch the last offered source and count offered cycles
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			seen_source_r <= '0;
			seen_cnt_r <= 16'h0000;
		end
		else if (req_valid)
		begin
			seen_source_r <= req_source;
			seen_cnt_r <= seen_cnt_r + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// *** tb_interrupt_flag_enable_priority.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_flag_enable_priority;
	import ifp_pkg::*;
	// Stimulus, all defined at time zero
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] src_set_0 = '0;
	logic [DATA_W-1:0] src_set_1 = '0;
	logic [XSRC-1:0] src_set_x = '0;
	logic [KIND_W-1:0] reset_kind = KIND_POWER_ON;
	logic [OSC_W-1:0] oscillator_config_word = 3'h5;
	// Observed outputs
	logic [DATA_W-1:0] reg_rdata;
	logic core_req_valid;
	logic [PRIO_W-1:0] core_req_priority;
	logic [IDX_W-1:0] core_req_source;
	logic irq_out;
	logic [IDX_W-1:0] seen_src;
	logic [15:0] seen_cnt;
	// Bookkeeping
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed;
	logic [3:0] ra;
	logic [15:0] rv;
	logic [15:0] tmp;

	ifp_ctrl ifp_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_set_0(src_set_0),
		.src_set_1(src_set_1), .src_set_x(src_set_x),
		.reset_kind(reset_kind),
		.oscillator_config_word(oscillator_config_word),
		.core_req_valid(core_req_valid),
		.core_req_priority(core_req_priority),
		.core_req_source(core_req_source), .irq_out(irq_out));
	ifp_core_model ifp_core_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.req_valid(core_req_valid), .req_source(core_req_source),
		.seen_source_r(seen_src), .seen_cnt_r(seen_cnt));

	// 200 MHz system clock
	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Hang guard, far above the planned run length
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			summarize();
		end
	end

	// Bits that keep what is written, per word index
	function automatic logic [15:0] wmask(input logic [3:0] a);
		case (a)
			4'h0, 4'h2: return FLAGS_0_MASK;
			4'h1, 4'h3: return FLAGS_1_MASK;
			4'h4, 4'h5: return PRIO_MASK;
			4'h6, 4'h7, 4'hb: return CAUSE_MASK;
			4'h8: return 16'h0007;
			4'ha: return STATUS_MASK;
			default: return 16'h0000;
		endcase
	endfunction

	// Value after a reset of kind k; osc fields from kind and config
	function automatic logic [15:0] rst_val(input logic [3:0] a,
		input logic [2:0] k, input logic [2:0] o, input logic [2:0] p);
		case (a)
			4'h4, 4'h5: return PRIO_RST;
			4'h8: return {13'h0000, GROUP_PRIO_RST};
			4'hb: return (16'h0001 << k) & CAUSE_MASK;
			4'hc: return (k <= 3'h1) ? {1'b0, o, 1'b0, o, 8'h00}
				: {1'b0, p, 1'b0, p, 8'h00};
			default: return ZERO_RST;
		endcase
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			error_cnt++;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		check(v, exp);
	endtask

	task automatic pulse(input logic [15:0] s0, input logic [15:0] s1,
		input logic [7:0] sx);
		@(posedge clk_sys);
		src_set_0 <= s0;
		src_set_1 <= s1;
		src_set_x <= sx;
		@(posedge clk_sys);
		src_set_0 <= '0;
		src_set_1 <= '0;
		src_set_x <= '0;
	endtask

	// Let state reach the registered request outputs
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic req_chk(input logic [2:0] p, input logic [5:0] s);
		check({6'h00, core_req_valid, core_req_priority, core_req_source},
			{6'h00, p != 3'h0, p, s});
	endtask

	// Reset, outputs idle during it, then every word against its value
	task automatic do_reset(input logic [2:0] k, input logic [2:0] o,
		input logic [2:0] p);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		reset_kind <= k;
		oscillator_config_word <= o;
		settle(10);
		check({14'h0000, core_req_valid, irq_out}, 16'h0000);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int a = 0; a < 16; a++)
			rd_chk(a[3:0], rst_val(a[3:0], k, o, p));
	endtask

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		seed = $urandom(32'h0f3932cf);
		do_reset(KIND_POWER_ON, 3'h5, 3'h0);
		// All ones written: dead bits stay zero
		for (int a = 0; a < 16; a++)
			if (a != 9 && a != 12 && a != 13)
			begin
				wr(a[3:0], 16'hffff);
				rd_chk(a[3:0], wmask(a[3:0]));
			end
		// Random words through word indices 0 to 8 of the writable map
		repeat (24)
		begin
			ra = 4'($urandom_range(0, 8));
			rv = 16'($urandom);
			wr(ra, rv);
			rd_chk(ra, rv & wmask(ra));
		end
		do_reset(KIND_BROWN_OUT, 3'h2, 3'h5);
		// Flag positions; enables still off, nothing forwarded
		pulse(16'h8188, 16'hffff, 8'h00);
		settle(2);
		req_chk(3'h0, 6'd0);
		rd_chk(OFF_FLAGS_0, 16'h0188);
		rd_chk(OFF_FLAGS_1, 16'h000b);
		wr(OFF_ENABLES_1, 16'h0008);
		settle(2);
		req_chk(3'h4, 6'd19);
		wr(OFF_ENABLES_0, 16'h0100);
		settle(2);
		req_chk(3'h4, 6'd8);
		wr(OFF_GROUP_PRIO, 16'h0000);
		settle(2);
		req_chk(3'h0, 6'd0);
		// Prioritised entries, rise event raises the interrupt
		wr(OFF_IRQ_MASK, 16'h0001);
		rd(OFF_IRQ_STATUS, tmp);
		wr(OFF_ENABLES_X, 16'h00ff);
		wr(OFF_PRIORITY_7, 16'h1357);
		wr(OFF_PRIORITY_17, 16'h0005);
		pulse(16'h0000, 16'h0000, 8'hff);
		settle(3);
		req_chk(3'h7, 6'd32);
		check({15'h0000, irq_out}, 16'h0001);
		rd_chk(OFF_REQ_VIEW, 16'h8720);
		rd_chk(OFF_IRQ_STATUS, 16'h0001);
		settle(2);
		check({15'h0000, irq_out}, 16'h0000);
		wr(OFF_PRIORITY_7, 16'h1350);
		settle(2);
		req_chk(3'h5, 6'd33);
		wr(OFF_PRIORITY_17, 16'h0007);
		settle(2);
		req_chk(3'h7, 6'd36);
		check({10'h000, seen_src}, 16'd36);
		// Request level stands while nothing changes
		tmp = seen_cnt;
		settle(4);
		check(seen_cnt - tmp, 16'd4);
		// Fall event is masked off the interrupt line
		wr(OFF_ENABLES_X, 16'h0000);
		settle(3);
		req_chk(3'h0, 6'd0);
		check({15'h0000, irq_out}, 16'h0000);
		rd_chk(OFF_IRQ_STATUS, 16'h0002);
		// Only the requested-oscillator field takes the written ones
		wr(OFF_OSC_CTL, 16'hffff);
		rd_chk(OFF_OSC_CTL, 16'h2700);
		// Source set and software clear in one cycle: set wins
		@(posedge clk_sys);
		reg_addr <= OFF_FLAGS_0;
		reg_wdata <= 16'h0000;
		reg_wr <= 1'b1;
		src_set_0 <= 16'h0008;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		src_set_0 <= '0;
		rd_chk(OFF_FLAGS_0, 16'h0008);
		wr(OFF_FLAGS_0, 16'h0001);
		do_reset(3'h4, 3'h7, 3'h2);
		summarize();
	end
endmodule
`default_nettype wire
